// File: rtl/ebr_pkg.sv
package ebr_pkg;
    // register byte addresses on the slave bus
    localparam logic [15:0] EBR_OFF_CTRL0 = 16'h0000; // region 0, step 4
    localparam logic [15:0] EBR_OFF_CTRL4 = 16'h0010; // bus_region_control
    localparam logic [15:0] EBR_OFF_WIN1 = 16'h0020; // windows 1..4, step 4
    localparam logic [15:0] EBR_OFF_STAT = 16'h0040;
    localparam logic [15:0] EBR_OFF_RPCFG = 16'hF108; // reset_port_config
    localparam int EBR_NREG = 5;
    // region control word fields
    localparam int EBR_F_WAIT = 0; // cycle_wait_field, 4 bits
    localparam int EBR_F_DLY = 4; // strobe_delay_bit
    localparam int EBR_F_TRI = 5; // tristate_wait_bit
    localparam int EBR_F_BUS_TYPE_FIELD = 6; // bus_type_field, 2 bits
    localparam int EBR_F_ALE = 9; // latch_lengthen_bit
    localparam int EBR_F_ACT = 10; // region_active_bit
    localparam int EBR_F_RDYEN = 12; // ready_handshake_enable
    localparam int EBR_F_RDYPOL = 13; // ready_polarity_bit
    localparam int EBR_F_CSR = 14; // read_select_gate
    localparam int EBR_F_CSW = 15; // write_select_gate
    localparam logic [15:0] EBR_CTRL_WMASK = 16'hF6FF; // bits 8, 11 reserved
    localparam logic [15:0] EBR_CTRL_RST = 16'h0000;
    localparam logic [15:0] EBR_WIN_RST = 16'h0000;
    localparam logic [3:0] EBR_WAIT_MAX = 4'hF;
    // reset_port_config fields
    localparam int EBR_R_WRC = 0; // write_mode_capture
    localparam int EBR_R_SELECT_LINE_COUNT = 1; // select_line_count, 2 bits
    localparam int EBR_R_SEGMENT_LINE_COUNT = 3; // segment_line_count, 2 bits
    localparam int EBR_R_CLOCK_MULTIPLIER_SELECT = 5; // clock_multiplier_select, 3 bits
    // config_port_zero pin positions
    localparam int EBR_P_CFG = 8; // upper byte feeds reset_port_config
    localparam int EBR_P_BUS_TYPE_FIELD = 16; // bits 16..17 feed the bus type
    // status register fields
    localparam int EBR_S_BUSY = 0;
    localparam int EBR_S_WMODE = 1; // system_write_mode_bit
    // bus cycle sequencer
    typedef enum logic [2:0] {
        EBR_ST_IDLE = 3'b000,
        EBR_ST_LATCH = 3'b001,
        EBR_ST_LATCH2 = 3'b010,
        EBR_ST_DELAY = 3'b011,
        EBR_ST_STROBE = 3'b100,
        EBR_ST_TRI = 3'b101,
        EBR_ST_DONE = 3'b110
    } ebr_state_t;
endpackage : ebr_pkg

// File: rtl/ebr_bus_ctrl.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// Summary of operation
// - wait-states per cycle are fifteen minus the cycle wait field.
// - strobe delay bit 0 adds one clock after address latch falls.
// - tristate bit 0 adds one wait-state at cycle end.
// - bus type: 8/16-bit, demultiplexed or multiplexed per two-bit field.
// - default region bus type comes from port bits 16 and 17 at reset end.
// - access pin high clears default region; low sets active, lengthen, type.
// - lengthen bit 1 stretches the address latch pulse.
// - external cycles only for active regions inside their window.
// - ready enable 1 waits for ready input, else wait count alone.
// - ready polarity bit selects low or high active ready level.
// - read gate 1 limits chip select to the read strobe.
// - write gate 1 limits chip select to the write strobe.
// - write capture 0 turns write and high-enable pins into byte writes.
// - captured select count enables three, two, none or five selects.
// - captured segment count enables four, none, eight or two lines.
// - clock multiplier field captured only on a long hardware reset.
// - reset configuration is read-only; its low five bits reload on every reset.
// - with pins pulled up the configuration byte reads FFh.
// - system write mode reads as inverted write capture bit.
module ebr_bus_ctrl
    import ebr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // reset straps
    input wire logic ext_access_pin,
    input wire logic long_reset,
    input wire logic [17:0] config_port_zero,
    output logic [2:0] clock_multiplier_select,
    // avalon-mm register slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // cpu access port
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [23:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic cpu_ack,
    output logic cpu_err,
    output logic [15:0] cpu_rdata,
    // external bus pins
    output logic [23:0] ext_addr,
    output logic [15:0] ext_ad_out,
    output logic ext_ad_oe,
    input wire logic [15:0] ext_ad_in,
    output logic ext_ale,
    output logic ext_rd_n,
    output logic ext_wr_n,
    output logic ext_bhe_n,
    output logic [4:0] ext_cs_n,
    input wire logic ext_ready
);

    logic [15:0] ctrl_reg [EBR_NREG];
    logic [15:0] win_reg [1:EBR_NREG-1];
    logic [7:0] rpcfg_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    ebr_state_t state_reg;
    ebr_state_t state_next;
    logic [2:0] rgn_reg;
    logic [15:0] cur_reg;
    logic [23:0] addr_reg;
    logic [15:0] wdata_reg;
    logic we_reg;
    logic [3:0] wait_reg;
    logic [15:0] rdata_cap_reg;
    logic err_reg;
    logic [2:0] rgn_sel;
    logic wr_acc;
    logic rdy_act;
    logic wait_done;
    logic strobe;
    logic mux_bus;
    logic wide_bus;
    logic cs_on;

    // windows hold base in [7:0] and mask in [15:8] over A23..A16
    function automatic logic win_hit(input logic [15:0] w,
                                     input logic [7:0] seg);
        win_hit = ((seg ^ w[7:0]) & w[15:8]) == 8'h00;
    endfunction : win_hit

    // number of chip-select lines let through
    function automatic logic [4:0] cs_mask(input logic [1:0] sel);
        case (sel)
            2'b00: cs_mask = 5'h07;
            2'b01: cs_mask = 5'h03;
            2'b10: cs_mask = 5'h00;
            default: cs_mask = 5'h1F;
        endcase
    endfunction : cs_mask

    // segment address lines A23..A16 let through
    function automatic logic [7:0] seg_mask(input logic [1:0] sel);
        case (sel)
            2'b00: seg_mask = 8'h0F;
            2'b01: seg_mask = 8'h00;
            2'b10: seg_mask = 8'hFF;
            default: seg_mask = 8'h03;
        endcase
    endfunction : seg_mask

    // lowest matching active window wins, region 0 takes the rest
    always_comb begin
        rgn_sel = 3'd0;
        for (int i = EBR_NREG - 1; i >= 1; i--) begin
            if (ctrl_reg[i][EBR_F_ACT] && win_hit(win_reg[i], cpu_addr[23:16]))
                rgn_sel = 3'(i);
        end
    end

    // one wait cycle on every access keeps the bus answer simple
    always_ff @(posedge clk)
        ack_reg <= !srst && (avs_read || avs_write) && !ack_reg;
    assign avs_waitrequest = !ack_reg;
    assign avs_readdata = rdata_reg;
    assign wr_acc = avs_write && ack_reg;

    // read mux, unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            rdata_reg <= 32'h0000_0000;
            if (avs_address == EBR_OFF_RPCFG)
                rdata_reg[7:0] <= rpcfg_reg;
            else if (avs_address == EBR_OFF_STAT) begin
                rdata_reg[EBR_S_BUSY] <= state_reg != EBR_ST_IDLE;
                rdata_reg[EBR_S_WMODE] <= !rpcfg_reg[EBR_R_WRC];
            end else begin
                for (int i = 0; i < EBR_NREG; i++)
                    if (avs_address == EBR_OFF_CTRL0 + 16'(4 * i))
                        rdata_reg[15:0] <= ctrl_reg[i];
                for (int i = 1; i < EBR_NREG; i++)
                    if (avs_address == EBR_OFF_WIN1 + 16'(4 * i - 4))
                        rdata_reg[15:0] <= win_reg[i];
            end
        end
    end

    // straps sampled on every clock of reset, last one stands
    always_ff @(posedge clk) begin
        if (srst) begin
            rpcfg_reg[4:0] <= config_port_zero[EBR_P_CFG +: 5];
            if (long_reset)
                rpcfg_reg[7:5] <= config_port_zero[EBR_P_CFG+5 +: 3];
        end
    end
    assign clock_multiplier_select = rpcfg_reg[EBR_R_CLOCK_MULTIPLIER_SELECT +: 3];

    // region control words; writes to the config register are dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < EBR_NREG; i++)
                ctrl_reg[i] <= EBR_CTRL_RST;
            if (!ext_access_pin) begin
                ctrl_reg[0][EBR_F_ACT] <= 1'b1;
                ctrl_reg[0][EBR_F_ALE] <= 1'b1;
                ctrl_reg[0][EBR_F_BUS_TYPE_FIELD +: 2] <=
                    config_port_zero[EBR_P_BUS_TYPE_FIELD +: 2];
            end
        end else if (wr_acc) begin
            for (int i = 0; i < EBR_NREG; i++) begin
                if (avs_address == EBR_OFF_CTRL0 + 16'(4 * i)) begin
                    if (avs_byteenable[0])
                        ctrl_reg[i][7:0] <= avs_writedata[7:0];
                    if (avs_byteenable[1])
                        ctrl_reg[i][15:8] <= avs_writedata[15:8]
                            & EBR_CTRL_WMASK[15:8];
                end
            end
        end
    end

    // address windows of regions 1..4
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 1; i < EBR_NREG; i++)
                win_reg[i] <= EBR_WIN_RST;
        end else if (wr_acc) begin
            for (int i = 1; i < EBR_NREG; i++) begin
                if (avs_address == EBR_OFF_WIN1 + 16'(4 * i - 4)) begin
                    if (avs_byteenable[0])
                        win_reg[i][7:0] <= avs_writedata[7:0];
                    if (avs_byteenable[1])
                        win_reg[i][15:8] <= avs_writedata[15:8];
                end
            end
        end
    end

    assign rdy_act = cur_reg[EBR_F_RDYPOL] ? ext_ready : !ext_ready;
    assign wait_done = (wait_reg == 4'h0) &&
        (!cur_reg[EBR_F_RDYEN] || rdy_act);

    // bus cycle sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            EBR_ST_IDLE:
                if (cpu_req)
                    state_next = ctrl_reg[rgn_sel][EBR_F_ACT] ?
                        EBR_ST_LATCH : EBR_ST_DONE;
            EBR_ST_LATCH:
                if (cur_reg[EBR_F_ALE])
                    state_next = EBR_ST_LATCH2;
                else
                    state_next = cur_reg[EBR_F_DLY] ?
                        EBR_ST_STROBE : EBR_ST_DELAY;
            EBR_ST_LATCH2:
                state_next = cur_reg[EBR_F_DLY] ?
                    EBR_ST_STROBE : EBR_ST_DELAY;
            EBR_ST_DELAY:
                state_next = EBR_ST_STROBE;
            EBR_ST_STROBE:
                if (wait_done)
                    state_next = cur_reg[EBR_F_TRI] ?
                        EBR_ST_DONE : EBR_ST_TRI;
            EBR_ST_TRI:
                state_next = EBR_ST_DONE;
            default:
                state_next = EBR_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
        state_reg <= srst ? EBR_ST_IDLE : state_next;

    // settings frozen at cycle start so a mid-cycle write cannot tear it
    always_ff @(posedge clk) begin
        if (srst) begin
            rgn_reg <= 3'd0;
            cur_reg <= EBR_CTRL_RST;
            addr_reg <= 24'h00_0000;
            wdata_reg <= 16'h0000;
            we_reg <= 1'b0;
            err_reg <= 1'b0;
        end else if (state_reg == EBR_ST_IDLE && cpu_req) begin
            rgn_reg <= rgn_sel;
            cur_reg <= ctrl_reg[rgn_sel];
            addr_reg <= cpu_addr;
            wdata_reg <= cpu_wdata;
            we_reg <= cpu_we;
            err_reg <= !ctrl_reg[rgn_sel][EBR_F_ACT];
        end
    end

    // wait-state counter, loaded as the latch phase ends
    always_ff @(posedge clk) begin
        if (srst)
            wait_reg <= 4'h0;
        else if (state_reg == EBR_ST_LATCH || state_reg == EBR_ST_LATCH2)
            wait_reg <= EBR_WAIT_MAX - cur_reg[EBR_F_WAIT +: 4];
        else if (state_reg == EBR_ST_STROBE && wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
    end

    // read data taken on the last strobe cycle; 8-bit bus zero-extends
    always_ff @(posedge clk) begin
        if (srst)
            rdata_cap_reg <= 16'h0000;
        else if (state_reg == EBR_ST_IDLE && cpu_req)
            rdata_cap_reg <= 16'h0000;
        else if (state_reg == EBR_ST_STROBE && wait_done && !we_reg)
            rdata_cap_reg <= wide_bus ? ext_ad_in
                : {8'h00, ext_ad_in[7:0]};
    end

    assign cpu_ack = state_reg == EBR_ST_DONE;
    assign cpu_err = cpu_ack && err_reg;
    assign cpu_rdata = rdata_cap_reg;

    // pin decode
    assign strobe = state_reg == EBR_ST_STROBE;
    assign mux_bus = cur_reg[EBR_F_BUS_TYPE_FIELD];
    assign wide_bus = cur_reg[EBR_F_BUS_TYPE_FIELD+1];
    assign ext_ale = state_reg == EBR_ST_LATCH ||
        state_reg == EBR_ST_LATCH2;
    assign ext_addr = {addr_reg[23:16] &
        seg_mask(rpcfg_reg[EBR_R_SEGMENT_LINE_COUNT +: 2]), addr_reg[15:0]};
    assign ext_ad_out = ext_ale && mux_bus ? addr_reg[15:0] : wdata_reg;
    assign ext_ad_oe = (ext_ale && mux_bus) || (we_reg &&
        (state_reg == EBR_ST_DELAY || strobe));
    assign ext_rd_n = !(strobe && !we_reg);

    // byte strobes when the write capture bit is clear
    always_comb begin
        ext_wr_n = !(strobe && we_reg);
        if (!rpcfg_reg[EBR_R_WRC])
            ext_bhe_n = !(strobe && we_reg && wide_bus);
        else
            ext_bhe_n = !(wide_bus && state_reg != EBR_ST_IDLE &&
                state_reg != EBR_ST_DONE);
    end

    // select spans the whole cycle unless gated to the strobe
    always_comb begin
        cs_on = state_reg != EBR_ST_IDLE && state_reg != EBR_ST_DONE &&
            !err_reg;
        if (!we_reg && cur_reg[EBR_F_CSR])
            cs_on = strobe;
        if (we_reg && cur_reg[EBR_F_CSW])
            cs_on = strobe;
        ext_cs_n = ~((5'h01 << rgn_reg) & {5{cs_on}}
            & cs_mask(rpcfg_reg[EBR_R_SELECT_LINE_COUNT +: 2]));
    end

    // checks
    a_wait_load: assert property (@(posedge clk) disable iff (srst)
        (strobe && !$past(strobe)) |->
            wait_reg == EBR_WAIT_MAX - cur_reg[EBR_F_WAIT +: 4])
        else $error("wait count not fifteen minus field");
    a_strobe_delay: assert property (@(posedge clk) disable iff (srst)
        $fell(ext_ale) |-> (strobe == cur_reg[EBR_F_DLY]))
        else $error("strobe delay does not follow delay bit");
    a_tristate_end: assert property (@(posedge clk) disable iff (srst)
        ($past(strobe) && !strobe) |->
            ((state_reg == EBR_ST_TRI) == !cur_reg[EBR_F_TRI]))
        else $error("tristate wait does not follow bit");
    a_mux_address: assert property (@(posedge clk) disable iff (srst)
        (ext_ale && mux_bus) |-> (ext_ad_oe && ext_ad_out == addr_reg[15:0]))
        else $error("address missing on multiplexed bus");
    a_default_reset: assert property (@(posedge clk)
        ($past(srst) && !srst && !$past(ext_access_pin)) |->
            (ctrl_reg[0][EBR_F_BUS_TYPE_FIELD +: 2] == $past(config_port_zero[17:16])
            && ctrl_reg[0][EBR_F_ACT] && ctrl_reg[0][EBR_F_ALE]))
        else $error("default region not loaded from straps");
    a_default_clear: assert property (@(posedge clk)
        ($past(srst) && !srst && $past(ext_access_pin)) |->
            ctrl_reg[0] == 16'h0000)
        else $error("default region not cleared");
    a_ale_length: assert property (@(posedge clk) disable iff (srst)
        $rose(ext_ale) |=> (ext_ale == cur_reg[EBR_F_ALE]))
        else $error("latch pulse length wrong");
    a_inactive_region: assert property (@(posedge clk) disable iff (srst)
        (state_reg == EBR_ST_LATCH) |-> (cur_reg[EBR_F_ACT] && !err_reg))
        else $error("cycle run for inactive region");
    a_ready_hold: assert property (@(posedge clk) disable iff (srst)
        (strobe && wait_reg == 4'h0 && cur_reg[EBR_F_RDYEN] && !rdy_act)
            |=> strobe)
        else $error("cycle ended without ready");
    a_read_gate: assert property (@(posedge clk) disable iff (srst)
        (ext_cs_n != 5'h1F && !we_reg && cur_reg[EBR_F_CSR]) |-> !ext_rd_n)
        else $error("select outside read strobe");
    a_write_gate: assert property (@(posedge clk) disable iff (srst)
        (ext_cs_n != 5'h1F && we_reg && cur_reg[EBR_F_CSW]) |-> !ext_wr_n)
        else $error("select outside write strobe");
    a_config_ro: assert property (@(posedge clk) disable iff (srst)
        wr_acc |=> $stable(rpcfg_reg))
        else $error("reset configuration changed by write");
    c_ready_cycle: cover property (@(posedge clk) disable iff (srst)
        strobe && cur_reg[EBR_F_RDYEN] && rdy_act);
    c_mux_write: cover property (@(posedge clk) disable iff (srst)
        cpu_ack && we_reg && mux_bus && !err_reg);
    c_refused: cover property (@(posedge clk) disable iff (srst)
        cpu_err);
endmodule : ebr_bus_ctrl

// File: sim/ebr_ext_mem.sv
`timescale 1ns/1ps
// external memory on the far side of the bus; ready comes after a delay
module ebr_ext_mem (
    // clock
    input wire logic clk,
    // bus pins driven by the block
    input wire logic [23:0] ext_addr,
    input wire logic [15:0] ext_ad_out,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    // answer lines back to the block
    output logic [15:0] ext_ad_in,
    output logic ext_ready,
    // behaviour knobs set by the bench
    input wire logic ready_pol,
    input wire logic [3:0] ready_dly
);
    logic [15:0] mem [256];
    logic [15:0] last_q = 16'h0000;
    logic [3:0] cnt = 4'h0;
    logic strobe;

    assign strobe = !ext_rd_n || !ext_wr_n;
    // store data every cycle the write strobe is low, count strobe cycles
    always @(posedge clk) begin
        if (!ext_wr_n) begin
            mem[ext_addr[7:0]] <= ext_ad_out;
        end
        if (!ext_rd_n) begin
            last_q <= mem[ext_addr[7:0]];
        end
        if (!strobe) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end
    // released lines show the inverse so a stale value never passes
    assign ext_ad_in = !ext_rd_n ? mem[ext_addr[7:0]] : ~last_q;
    // active level only once the delay has run out
    assign ext_ready = (cnt >= ready_dly) ? ready_pol : !ready_pol;
endmodule : ebr_ext_mem

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import ebr_pkg::*;
    logic clk = 1'b0, srst, ext_access_pin, long_reset, avs_read, avs_write;
    logic [17:0] config_port_zero;
    logic [2:0] clock_multiplier_select;
    logic [15:0] avs_address, cpu_wdata, cpu_rdata, ext_ad_out, ext_ad_in;
    logic [31:0] avs_writedata, avs_readdata, rd, rnd;
    logic [3:0] avs_byteenable, rdly;
    logic avs_waitrequest, cpu_req, cpu_we, cpu_ack, cpu_err, ext_ad_oe;
    logic [23:0] cpu_addr, ext_addr, adr;
    logic ext_ale, ext_rd_n, ext_wr_n, ext_bhe_n, ext_ready, rpol, err, strb;
    logic [4:0] ext_cs_n, csv;
    logic [7:0] sa;
    logic bh;
    logic [15:0] ctrl, cur_ctrl, dat, q;
    int bad_count = 0, checks_done = 0, viol = 0, n;

    ebr_bus_ctrl DUT (.clk(clk), .srst(srst), .ext_access_pin(ext_access_pin),
        .long_reset(long_reset), .config_port_zero(config_port_zero),
        .clock_multiplier_select(clock_multiplier_select),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req),
        .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata),
        .ext_addr(ext_addr), .ext_ad_out(ext_ad_out), .ext_ad_oe(ext_ad_oe),
        .ext_ad_in(ext_ad_in), .ext_ale(ext_ale), .ext_rd_n(ext_rd_n),
        .ext_wr_n(ext_wr_n), .ext_bhe_n(ext_bhe_n), .ext_cs_n(ext_cs_n),
        .ext_ready(ext_ready));
    ebr_ext_mem mem_u (.clk(clk), .ext_addr(ext_addr),
        .ext_ad_out(ext_ad_out), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
        .ext_ad_in(ext_ad_in), .ext_ready(ext_ready), .ready_pol(rpol),
        .ready_dly(rdly));

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // straps held steady for the whole reset pulse
    task automatic do_reset(input logic ea, input logic lr,
                            input logic [17:0] p);
        ext_access_pin <= ea;
        long_reset <= lr;
        config_port_zero <= p;
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    // one avalon transfer; idle edge after it so strobes never re-rise
    task automatic av(input logic wr, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int t;
        t = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        check("av wait", t, 2);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : av

    // one cpu access; watches the select gating while it runs
    task automatic cpu(input logic we, input logic [23:0] a,
                       input logic [15:0] d, output logic [15:0] r,
                       output int k, output logic e);
        k = 0;
        strb = 1'b0;
        cpu_we <= we;
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_req <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (!ext_rd_n || !ext_wr_n) begin
                strb = 1'b1;
                csv = ext_cs_n;
                sa = ext_addr[23:16];
                bh = ext_bhe_n;
            end
            if (cur_ctrl[14] && !ext_cs_n[0] && ext_rd_n && !we) viol++;
            if (cur_ctrl[15] && !ext_cs_n[0] && ext_wr_n && we) viol++;
        end while (cpu_ack !== 1'b1 && k < 100);
        e = cpu_err;
        r = cpu_rdata;
        cpu_req <= 1'b0;
        @(posedge clk);
    endtask : cpu

    function automatic int exp_cyc(input logic [15:0] c);
        return 4 + c[9] + !c[4] + (15 - c[3:0]) + !c[5];
    endfunction : exp_cyc

    task automatic set_ctrl(input logic [15:0] c);
        cur_ctrl = c;
        av(1'b1, EBR_OFF_CTRL0, {16'h0000, c}, rd);
    endtask : set_ctrl

    // cuts a hang short
    initial begin
        #(64'd4_000_000);
        bad_count++;
        report_and_stop();
    end

    initial begin
        {avs_read, avs_write, cpu_req, cpu_we, rpol} = 5'h00;
        avs_address = 16'h0000;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h3;
        cpu_addr = 24'h00_0000;
        cpu_wdata = 16'h0000;
        rdly = 4'h0;
        cur_ctrl = 16'h0000;
        rnd = $urandom(32'h754B);
        do_reset(1'b0, 1'b1, 18'h3FF00);
        av(1'b0, EBR_OFF_RPCFG, 32'h0, rd);
        check("rpcfg", rd, 32'h0000_00FF);
        check("clock_multiplier_select", clock_multiplier_select, 3'h7);
        av(1'b0, EBR_OFF_CTRL0, 32'h0, rd);
        check("ctrl0", rd, 32'h0000_06C0);
        check("ctrl0 type", rd[7:6], 2'h3);
        av(1'b0, EBR_OFF_STAT, 32'h0, rd);
        check("wmode", rd[EBR_S_WMODE], 1'b0);
        av(1'b1, EBR_OFF_RPCFG, 32'h0000_0000, rd);
        av(1'b0, EBR_OFF_RPCFG, 32'h0, rd);
        check("rpcfg ro", rd, 32'h0000_00FF);
        av(1'b0, 16'h0098, 32'h0, rd);
        check("unmapped", rd, 32'h0000_0000);
        dat = $urandom;
        av(1'b1, EBR_OFF_CTRL4, {16'h0000, dat}, rd);
        av(1'b0, EBR_OFF_CTRL4, 32'h0, rd);
        check("ctrl4", rd, {16'h0000, dat & EBR_CTRL_WMASK});
        av(1'b1, EBR_OFF_CTRL4, 32'h0, rd);
        // timing sweep, boundary wait fields first, then random
        for (int i = 0; i < 14; i++) begin
            rnd = $urandom;
            ctrl = {rnd[15:14], 4'h1, rnd[9], 1'b0, 1'b1, rnd[6], rnd[5:0]};
            if (i < 2) ctrl[3:0] = i ? 4'hF : 4'h0;
            set_ctrl(ctrl);
            adr = {rnd[31:24], 8'h00, rnd[23:16]};
            dat = $urandom;
            cpu(1'b1, adr, dat, q, n, err);
            check("wr cycles", n, exp_cyc(ctrl));
            cpu(1'b0, adr, 16'h0000, q, n, err);
            check("rd cycles", n, exp_cyc(ctrl));
            check("rd data", q, dat);
            check("rd cs", csv, 5'h1E);
            check("rd seg", sa, adr[23:16] & 8'h03);
            check("rd bhe", bh, 1'b0);
        end
        // 8-bit buses return the low byte only
        for (int b = 0; b < 2; b++) begin
            set_ctrl(16'h040F | 16'(b << 6));
            cpu(1'b0, adr, 16'h0000, q, n, err);
            check("rd8", q, {8'h00, dat[7:0]});
            check("rd8 bhe", bh, 1'b1);
        end
        // ready handshake, both polarities
        for (int p = 0; p < 2; p++) begin
            rpol = p[0];
            rdly = 4'h3;
            set_ctrl(16'h14BF | 16'(p << 13));
            cpu(1'b0, adr, 16'h0000, q, n, err);
            check("rdy wait", n, exp_cyc(16'h14BF) + 3);
            check("rdy data", q, dat);
        end
        rdly = 4'h0;
        // inactive region refuses without strobing the pins
        set_ctrl(16'h008F);
        cpu(1'b0, adr, 16'h0000, q, n, err);
        check("inactive err", err, 1'b1);
        check("inactive cycles", n, 2);
        check("inactive pins", strb, 1'b0);
        check("cs gating", viol, 0);
        // region 4 window claims segment 5A over the inactive default
        av(1'b1, EBR_OFF_WIN1 + 16'h000C, 32'h0000_FF5A, rd);
        av(1'b1, EBR_OFF_CTRL4, 32'h0000_04BF, rd);
        cpu(1'b0, {8'h5A, adr[15:0]}, 16'h0000, q, n, err);
        check("win cs", csv, 5'h0F);
        check("win cycles", n, exp_cyc(16'h04BF));
        check("win data", q, dat);
        // short reset with access pin high and random straps
        rnd = $urandom;
        do_reset(1'b1, 1'b0, {2'h2, rnd[7:0], 8'h00});
        av(1'b0, EBR_OFF_CTRL0, 32'h0, rd);
        check("ctrl0 ea", rd, 32'h0000_0000);
        av(1'b0, EBR_OFF_RPCFG, 32'h0, rd);
        check("rpcfg low", rd[4:0], rnd[4:0]);
        check("clk kept", rd[7:5], 3'h7);
        av(1'b0, EBR_OFF_STAT, 32'h0, rd);
        check("wmode inv", rd[EBR_S_WMODE], !rnd[0]);
        report_and_stop();
    end
endmodule : tb
